// ==== core/imcs_core.sv ====
// Overview of operation
// - 16-bit I/O cycle keeps address and byte-high enable 19T after strobe.
// - Memory strobe assertion to next address latch pulse at least 10T.
// - I/O strobe assertion to next address latch pulse at least 10T.
// - Memory strobes spaced at least 12T assertion to assertion.
// - I/O strobes spaced at least 12T assertion to assertion.
// - At least 3T recovery from strobe release to next strobe.
// - Next address latch pulse starts at least 1T after strobe release.
`timescale 1ns/100ps
`default_nettype none
`include "imcs_regs.svh"

module imcs_core
  import imcs_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        ISA_DOUBLE_RATE_CLOCK_I,
  input  wire logic        REQ_VALID_I,
  input  wire imcs_req_t   REQ_I,
  output var  logic        REQ_READY_O,
  output var  logic        RSP_VALID_O,
  output var  logic [15:0] RSP_RDATA_O,
  input  wire logic        IOCHRDY_I,
  input  wire logic [15:0] SD_I,
  output var  logic [15:0] SD_O,
  output var  logic        SD_OE_O,
  output var  logic        ALE_O,
  output var  logic [19:0] SA_O,
  output var  logic        SBHE_N_O,
  output var  logic [6:0]  LA_O,
  output var  logic        MEMR_N_O,
  output var  logic        MEMW_N_O,
  output var  logic        SMEMR_N_O,
  output var  logic        SMEMW_N_O,
  output var  logic        IOR_N_O,
  output var  logic        IOW_N_O
);

  logic [2:0]  clk_sync;
  logic [1:0]  rdy_sync;
  logic [15:0] sd_s1;
  logic [15:0] sd_s2;
  logic        tick;
  imcs_state_t state;
  imcs_req_t   req;
  logic        have_req;
  logic [4:0]  cnt;
  logic [4:0]  since_cmd;
  logic [4:0]  since_rel;
  imcs_cmd_t   cmd;
  logic        ale_ok;
  logic        cmd_ok;
  logic        fire_ale;
  logic        fire_cmd;
  logic        fire_rel;
  logic        hold_done;

  function automatic logic [4:0] sat_inc(input logic [4:0] v);
    sat_inc = (v == `IMCS_T_SAT) ? v : v + 5'h01;
  endfunction : sat_inc

  // Strobe width by slave width and space: 8-bit I/O gets the extended length
  function automatic logic [4:0] cmd_len(input imcs_req_t r);
    cmd_len = (r.is_io && !r.wide) ? `IMCS_T_CMD_EXT : `IMCS_T_CMD_STD;
  endfunction : cmd_len

  function automatic imcs_cmd_t cmd_sel(input imcs_req_t r);
    imcs_cmd_t c;
    logic      lowmeg;
    c = '0;
    lowmeg = (r.addr[23:20] == `IMCS_LOWMEG_TOP);
    if (r.is_io) begin
      c.ior = !r.is_write;
      c.iow = r.is_write;
    end else if (lowmeg) begin
      c.smemr = !r.is_write;
      c.smemw = r.is_write;
    end else begin
      c.memr = !r.is_write;
      c.memw = r.is_write;
    end
    cmd_sel = c;
  endfunction : cmd_sel

  // The ISA clock is sampled; clk_sync[0] is read only by clk_sync[1]
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      clk_sync <= 3'h0;
      rdy_sync <= 2'h3;
      sd_s1    <= 16'h0000;
      sd_s2    <= 16'h0000;
    end else begin
      clk_sync <= {clk_sync[1:0], ISA_DOUBLE_RATE_CLOCK_I};
      rdy_sync <= {rdy_sync[0], IOCHRDY_I};
      sd_s1    <= SD_I;
      sd_s2    <= sd_s1;
    end
  end

  assign tick = clk_sync[1] && !clk_sync[2];

  assign ale_ok    = (since_cmd >= `IMCS_T_CMD_TO_ALE) && (since_rel >= `IMCS_T_REL_TO_ALE);
  assign cmd_ok    = (since_cmd >= `IMCS_T_CMD_TO_CMD) && (since_rel >= `IMCS_T_REL_TO_CMD);
  assign fire_ale  = tick && (state == IMCS_IDLE) && have_req && ale_ok;
  assign fire_cmd  = tick && (state == IMCS_SETUP) && (cnt >= `IMCS_T_ALE_TO_CMD) && cmd_ok;
  // Ready low keeps the strobe on; the slave can only stretch it beyond cmd_len(req)
  assign fire_rel  = tick && (state == IMCS_STROBE) && (cnt >= cmd_len(req)) && rdy_sync[1];
  assign hold_done = (req.is_io && req.wide) ? (since_cmd >= `IMCS_T_IO16_ADDR_HOLD)
                                             : (since_cmd >= `IMCS_T_ADDR_HOLD);

  // Spacing counters start saturated so the first cycle is not delayed
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      since_cmd <= `IMCS_T_SAT;
      since_rel <= `IMCS_T_SAT;
    end else if (tick) begin
      since_cmd <= fire_cmd ? 5'h00 : sat_inc(since_cmd);
      since_rel <= fire_rel ? 5'h00 : sat_inc(since_rel);
    end
  end

  // Request intake: one request in flight, accepted only while idle
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      have_req    <= 1'b0;
      req         <= '0;
      REQ_READY_O <= 1'b0;
    end else begin
      if (REQ_VALID_I && REQ_READY_O) begin
        have_req    <= 1'b1;
        req         <= REQ_I;
        REQ_READY_O <= 1'b0;
      end else if (tick && (state == IMCS_HOLD) && hold_done) begin
        have_req    <= 1'b0;
        REQ_READY_O <= 1'b1;
      end else begin
        REQ_READY_O <= !have_req && (state == IMCS_IDLE);
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state <= IMCS_IDLE;
      cnt   <= 5'h00;
    end else if (tick) begin
      case (state)
        IMCS_IDLE: begin
          if (fire_ale) begin
            state <= IMCS_LATCH;
            cnt   <= `IMCS_T_ALE_WIDTH;
          end
        end
        IMCS_LATCH: begin
          state <= IMCS_SETUP;
          cnt   <= sat_inc(cnt);
        end
        IMCS_SETUP: begin
          if (fire_cmd) begin
            state <= IMCS_STROBE;
            cnt   <= 5'h01;
          end else begin
            cnt <= sat_inc(cnt);
          end
        end
        IMCS_STROBE: begin
          if (fire_rel) begin
            state <= IMCS_HOLD;
          end
          cnt <= sat_inc(cnt);
        end
        IMCS_HOLD: begin
          if (hold_done) begin
            state <= IMCS_IDLE;
          end
        end
        default: begin
          state <= IMCS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      cmd <= '0;
    end else if (fire_cmd) begin
      cmd <= cmd_sel(req);
    end else if (fire_rel) begin
      cmd <= '0;
    end
  end

  // Address and data pins; address stays put through the hold phase
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ALE_O    <= 1'b0;
      SA_O     <= 20'h00000;
      SBHE_N_O <= 1'b1;
      LA_O     <= 7'h00;
      SD_O     <= 16'h0000;
      SD_OE_O  <= 1'b0;
    end else begin
      if (fire_ale) begin
        ALE_O    <= 1'b1;
        SA_O     <= req.addr[19:0];
        SBHE_N_O <= !(req.wide || req.addr[0]);
        LA_O     <= req.addr[23:17];
        SD_O     <= req.wdata;
        SD_OE_O  <= req.is_write;
      end else if (tick && (state == IMCS_LATCH)) begin
        ALE_O <= 1'b0;
      end
      if (fire_rel) begin
        SD_OE_O <= 1'b0;
      end
    end
  end

  // Read data was settled on the bus two clocks before the release edge
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      RSP_VALID_O <= 1'b0;
      RSP_RDATA_O <= 16'h0000;
    end else begin
      RSP_VALID_O <= fire_rel;
      if (fire_rel && !req.is_write) begin
        RSP_RDATA_O <= sd_s2;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      MEMR_N_O  <= 1'b1;
      MEMW_N_O  <= 1'b1;
      SMEMR_N_O <= 1'b1;
      SMEMW_N_O <= 1'b1;
      IOR_N_O   <= 1'b1;
      IOW_N_O   <= 1'b1;
    end else begin
      MEMR_N_O  <= !cmd.memr;
      MEMW_N_O  <= !cmd.memw;
      SMEMR_N_O <= !cmd.smemr;
      SMEMW_N_O <= !cmd.smemw;
      IOR_N_O   <= !cmd.ior;
      IOW_N_O   <= !cmd.iow;
    end
  end

endmodule : imcs_core
`default_nettype wire

// ==== common/imcs_regs.svh ====
`ifndef IMCS_REGS_SVH
`define IMCS_REGS_SVH

// All spacings counted in periods of the double-rate ISA clock
`define IMCS_T_CMD_TO_ALE     5'd10
`define IMCS_T_CMD_TO_CMD     5'd12
`define IMCS_T_REL_TO_CMD     5'd3
`define IMCS_T_REL_TO_ALE     5'd1
`define IMCS_T_IO16_ADDR_HOLD 5'd19
`define IMCS_T_ADDR_HOLD      5'd10
`define IMCS_T_ALE_WIDTH      5'd1
`define IMCS_T_ALE_TO_CMD     5'd2
`define IMCS_T_CMD_STD        5'd9
`define IMCS_T_CMD_EXT        5'd11
`define IMCS_T_SAT            5'h1f
`define IMCS_LOWMEG_TOP       4'h0

`endif

// ==== common/imcs_pkg.sv ====
package imcs_pkg;

  // One bus request from the user side
  typedef struct packed {
    logic        is_io;
    logic        is_write;
    logic        wide;
    logic [23:0] addr;
    logic [15:0] wdata;
  } imcs_req_t;

  // Command strobes, active high inside the block
  typedef struct packed {
    logic memr;
    logic memw;
    logic smemr;
    logic smemw;
    logic ior;
    logic iow;
  } imcs_cmd_t;

  typedef enum logic [2:0] {
    IMCS_IDLE,
    IMCS_LATCH,
    IMCS_SETUP,
    IMCS_STROBE,
    IMCS_HOLD
  } imcs_state_t;

endpackage : imcs_pkg

// ==== test/imcs_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module imcs_properties
  import imcs_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        ISA_DOUBLE_RATE_CLOCK_I,
  input wire logic        REQ_VALID_I,
  input wire imcs_req_t   REQ_I,
  input wire logic        REQ_READY_O,
  input wire logic        IOCHRDY_I,
  input wire logic        ALE_O,
  input wire logic [19:0] SA_O,
  input wire logic        SBHE_N_O,
  input wire logic [6:0]  LA_O,
  input wire logic        MEMR_N_O,
  input wire logic        MEMW_N_O,
  input wire logic        SMEMR_N_O,
  input wire logic        SMEMW_N_O,
  input wire logic        IOR_N_O,
  input wire logic        IOW_N_O
);
  logic       isa_q, any_q, wide_q, io16;
  logic [4:0] cnt_asrt, cnt_rel;
  wire any_cmd = ~&{MEMR_N_O, MEMW_N_O, SMEMR_N_O, SMEMW_N_O, IOR_N_O, IOW_N_O};
  // Our tick leads the design's synchronised tick, so counts between outputs match
  wire tick = ISA_DOUBLE_RATE_CLOCK_I & ~isa_q;
  always_ff @(posedge CLK_I) begin
    isa_q <= ISA_DOUBLE_RATE_CLOCK_I;
    any_q <= any_cmd;
    if (REQ_VALID_I && REQ_READY_O) wide_q <= REQ_I.wide;
    if (any_cmd && !any_q) io16 <= wide_q && !(IOR_N_O && IOW_N_O);
  end
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      cnt_asrt <= 5'h1f;
      cnt_rel  <= 5'h1f;
    end else begin
      if (any_cmd && !any_q) cnt_asrt <= 5'h0;
      else if (tick && cnt_asrt != 5'h1f) cnt_asrt <= cnt_asrt + 5'h1;
      if (!any_cmd && any_q) cnt_rel <= 5'h0;
      else if (tick && cnt_rel != 5'h1f) cnt_rel <= cnt_rel + 5'h1;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  io_hold_a: assert property (io16 && ($changed(SA_O) || $changed(SBHE_N_O)) |-> cnt_asrt >= 5'd19)
    else $error("address moved too soon after 16-bit io strobe");
  cmd_ale_a: assert property ($rose(ALE_O) |-> cnt_asrt >= 5'd10)
    else $error("latch pulse too soon after strobe");
  cmd_space_a: assert property ($rose(any_cmd) |-> cnt_asrt >= 5'd12)
    else $error("strobes too close");
  cmd_recov_a: assert property ($rose(any_cmd) |-> cnt_rel >= 5'd3)
    else $error("recovery too short");
  rel_ale_a: assert property ($rose(ALE_O) |-> cnt_rel >= 5'd1)
    else $error("latch pulse too soon after release");
  ready_hold_a: assert property ($fell(any_cmd) |-> $past(IOCHRDY_I, 2))
    else $error("strobe ended while ready low");
  space_sel_a: assert property ($fell(SMEMR_N_O) || $fell(SMEMW_N_O) |-> LA_O[6:3] == 4'h0)
    else $error("low strobe used above first megabyte");
  ale_width_a: assert property ($rose(ALE_O) |-> ALE_O [*8] ##[5:12] !ALE_O)
    else $error("latch pulse width wrong");
endmodule : imcs_properties
`default_nettype wire

// ==== test/imcs_slave_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module imcs_slave_model (
  input  wire logic        isa_clk_i,
  input  wire logic        rd_n_i,
  input  wire logic        cmd_n_i,
  input  wire logic [3:0]  wait_i,
  input  wire logic [15:0] rdata_i,
  output var  logic        rdy_o,
  output var  logic [15:0] sd_o
);
  int t = 0;
  initial begin
    rdy_o = 1'b1;
    sd_o  = 16'h0;
  end
  // Ready drops 2T after strobe; released bus toggles so stale data never matches
  always @(posedge isa_clk_i) begin
    if (cmd_n_i) begin
      t <= 0;
      rdy_o <= 1'b1;
      sd_o <= ~sd_o;
    end else begin
      t <= t + 1;
      rdy_o <= !(t >= 1 && t < 1 + wait_i);
      if (!rd_n_i && t == 1) sd_o <= rdata_i;
    end
  end
endmodule : imcs_slave_model
`default_nettype wire

// ==== test/test_isa_master_cycle_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,a) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_isa_master_cycle_sequencer
  import imcs_pkg::*;
;
  logic        clk = 0, rst = 1, isa_clk = 0, req_valid = 0, iochrdy, ready, rsp_valid, ale, sbhe_n;
  logic        sd_oe, oe_seen;
  imcs_req_t   req = '0;
  logic [15:0] sd_in, sd_out, rsp_rdata, rdata_m = 16'h0;
  logic [3:0]  wait_n = 4'h0;
  logic [19:0] sa;
  logic [6:0]  la;
  logic [5:0]  strb_n, seen;
  int          n_mismatch = 0, n_compared = 0, width;
  initial forever #2.5 clk = ~clk;
  initial begin
    #7;
    forever #40 isa_clk = ~isa_clk;
  end
  imcs_core u_dut (.CLK_I(clk), .SYS_RST_I(rst), .ISA_DOUBLE_RATE_CLOCK_I(isa_clk), .REQ_VALID_I(req_valid),
    .REQ_I(req), .REQ_READY_O(ready), .RSP_VALID_O(rsp_valid), .RSP_RDATA_O(rsp_rdata), .IOCHRDY_I(iochrdy),
    .SD_I(sd_in), .SD_O(sd_out), .SD_OE_O(sd_oe), .ALE_O(ale), .SA_O(sa), .SBHE_N_O(sbhe_n), .LA_O(la),
    .MEMR_N_O(strb_n[5]), .MEMW_N_O(strb_n[4]), .SMEMR_N_O(strb_n[3]), .SMEMW_N_O(strb_n[2]),
    .IOR_N_O(strb_n[1]), .IOW_N_O(strb_n[0]));
  imcs_slave_model u_slv (.isa_clk_i(isa_clk), .rd_n_i(strb_n[5] & strb_n[3] & strb_n[1]), .cmd_n_i(&strb_n),
    .wait_i(wait_n), .rdata_i(rdata_m), .rdy_o(iochrdy), .sd_o(sd_in));
  always @(posedge clk) begin
    seen <= seen | ~strb_n;
    oe_seen <= oe_seen | (sd_oe & (~&strb_n));
    if (~&strb_n) width <= width + 1;
  end
  task xfer(input logic io, input logic wr, input logic wd, input logic [23:0] a, input logic [5:0] es);
    int k;
    k = 0;
    while (!ready && k < 2000) begin
      @(posedge clk);
      #1 k++;
    end
    `CHK("ready", 1'b1, ready);
    req = '{io, wr, wd, a, a[15:0]};
    req_valid = 1'b1;
    seen = '0;
    oe_seen = 1'b0;
    width = 0;
    @(posedge clk);
    #1 req_valid = 1'b0;
    k = 0;
    while (!rsp_valid && k < 2000) begin
      @(posedge clk);
      #1 k++;
    end
    `CHK("rsp_valid", 1'b1, rsp_valid);
    // The strobe is still low at the next edge; wait so the width count is complete
    @(posedge clk);
    #1;
    `CHK("rsp_pulse", 1'b0, rsp_valid);
    `CHK("release", 6'h3f, strb_n);
    `CHK("strobe", es, seen);
    if (!wr) `CHK("rdata", rdata_m, rsp_rdata);
    if (wr) `CHK("wdata", a[15:0], sd_out);
    `CHK("sd_oe", wr, oe_seen);
    `CHK("sd_oe_off", 1'b0, sd_oe);
    `CHK("sbhe", ~(wd | a[0]), sbhe_n);
    `CHK("la", a[23:17], la);
    `CHK("sa", a[19:0], sa);
  endtask : xfer
  task t_space;
    rdata_m = 16'h5a3c;
    xfer(1'b0, 1'b0, 1'b1, 24'h012344, 6'h08);
    `CHK("width", 144, width);
    xfer(1'b0, 1'b0, 1'b0, 24'h0c8001, 6'h08);
    xfer(1'b0, 1'b1, 1'b1, 24'hf00002, 6'h10);
    xfer(1'b0, 1'b1, 1'b0, 24'h000003, 6'h04);
  endtask : t_space
  task t_io;
    rdata_m = 16'ha5c3;
    xfer(1'b1, 1'b0, 1'b1, 24'h0003f8, 6'h02);
    xfer(1'b1, 1'b1, 1'b0, 24'h000379, 6'h01);
    `CHK("width", 176, width);
    xfer(1'b1, 1'b1, 1'b1, 24'h000380, 6'h01);
  endtask : t_io
  task t_wait;
    wait_n = 4'hc;
    rdata_m = 16'h3c96;
    xfer(1'b0, 1'b0, 1'b1, 24'h100000, 6'h20);
    // Ready is low for twelve T from 2T after the strobe, so the strobe ends at 14T
    `CHK("width", 224, width);
    wait_n = 4'h0;
  endtask : t_wait
  task summarize;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    t_space;
    t_io;
    t_wait;
    summarize;
  end
  // Eight transfers need about 11 us; some nine times that marks a hang
  initial begin
    #100000;
    n_mismatch++;
    summarize;
  end
endmodule : test_isa_master_cycle_sequencer
bind imcs_core imcs_properties u_prop (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .ISA_DOUBLE_RATE_CLOCK_I(ISA_DOUBLE_RATE_CLOCK_I), .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I),
  .REQ_READY_O(REQ_READY_O), .IOCHRDY_I(IOCHRDY_I), .ALE_O(ALE_O), .SA_O(SA_O), .SBHE_N_O(SBHE_N_O),
  .LA_O(LA_O), .MEMR_N_O(MEMR_N_O), .MEMW_N_O(MEMW_N_O), .SMEMR_N_O(SMEMR_N_O), .SMEMW_N_O(SMEMW_N_O),
  .IOR_N_O(IOR_N_O), .IOW_N_O(IOW_N_O));
`default_nettype wire
